//--- rtl/irq_flag_pkg.sv
`default_nettype none
package irq_flag_pkg;
	// instruction clock: four phases of ref_clk per instruction cycle
	localparam int CLK_PERIOD_NS    = 8;
	localparam int PHASES_PER_TCY   = 4;
	localparam int TCY_NS           = CLK_PERIOD_NS * PHASES_PER_TCY;
	localparam int SYNC_LATENCY_TCY = 3;
	localparam int LATENCY_CLKS     = SYNC_LATENCY_TCY * TCY_NS / CLK_PERIOD_NS;

	localparam int PC_W   = 13;
	localparam int ADDR_W = 3;
	localparam int PORT_W = 6;

	localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;

	localparam logic [ADDR_W-1:0] ADDR_CORE    = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_PORTSEL = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_PFLAGS  = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_PEN     = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_OPTION  = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_EVSTAT  = 3'h5;
	localparam logic [ADDR_W-1:0] ADDR_EVMASK  = 3'h6;

	localparam int GLOBAL_EN_BIT  = 7;
	localparam int PERIPH_EN_BIT  = 6;
	localparam int TIMER_EN_BIT   = 5;
	localparam int EDGE_EN_BIT    = 4;
	localparam int PORT_EN_BIT    = 3;
	localparam int TIMER_FLAG_BIT = 2;
	localparam int EDGE_FLAG_BIT  = 1;
	localparam int PORT_FLAG_BIT  = 0;
	localparam int EDGE_POL_BIT = 6;

	localparam logic [7:0] CORE_RESET    = 8'h00;
	localparam logic [7:0] PORTSEL_RESET = 8'h00;
	localparam logic [7:0] PFLAGS_RESET  = 8'h00;
	localparam logic [7:0] PEN_RESET     = 8'h00;
	localparam logic       EDGE_POL_RESET = 1'b1;
	localparam logic [7:0] PORTSEL_MASK  = 8'h3F;
	localparam logic [7:0] PFLAGS_MASK   = 8'hFD;

	localparam int EV_W          = 2;
	localparam int EV_VECTOR_BIT = 0;
	localparam int EV_RETURN_BIT = 1;
	localparam logic [EV_W-1:0] EV_RESET = 2'h0;

	localparam int BANK_W   = 2;
	localparam int OFFS_W   = 7;
	localparam logic [OFFS_W-1:0] COMMON_SIZE = 7'h10;

	typedef enum logic [3:0] {
		PH_Q1 = 4'b0001,
		PH_Q2 = 4'b0010,
		PH_Q3 = 4'b0100,
		PH_Q4 = 4'b1000
	} phase_t;

	typedef enum logic [3:0] {
		SEQ_IDLE   = 4'b0001,
		SEQ_ARMED  = 4'b0010,
		SEQ_DUMMY  = 4'b0100,
		SEQ_VECTOR = 4'b1000
	} seq_t;
endpackage
`default_nettype wire

//--- rtl/irq_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module irq_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	// meta_q feeds sync_q only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= pinIn;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

//--- rtl/irq_common_map.sv
`timescale 1ns/1ps
`default_nettype none
module irq_common_map
	import irq_flag_pkg::*;
(
	input  wire logic [BANK_W-1:0]        bankSel,
	input  wire logic [OFFS_W-1:0]        offset,
	output logic      [BANK_W+OFFS_W-1:0] physAddr
);
	// low locations fold onto bank 0 whatever the bank select
	assign physAddr = (offset < COMMON_SIZE) ? {{BANK_W{1'b0}}, offset} : {bankSel, offset};
endmodule
`default_nettype wire

//--- rtl/irq_flag_vector_logic.sv
// Function
// - An event asynchronous to the instruction clock reaches the vector in three to four instruction cycles.
// - An event synchronous to the instruction clock reaches the vector in exactly three instruction cycles.
// - Latency does not depend on whether the executing instruction takes one or two cycles.
// - The edge pin flag may only become set from phase four of one cycle through phase one of the next.
// - Taking an interrupt pushes only the return program counter and nothing else.
// - The lowest sixteen data locations map to the same place in every bank.
// - Servicing clears the global enable, pushes the return address and loads the fixed vector.
// - Each flag is set by its event whatever its own enable or the global enable.
// - The edge pin triggers on a rising edge when polarity select is set, else on a falling edge.
// - The return-from-interrupt instruction sets the global enable again.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module irq_flag_vector_logic
	import irq_flag_pkg::*;
(
	input  wire logic                      ref_clk,
	input  wire logic                      rst_b,
	input  wire logic [ADDR_W-1:0]         regAddr,
	input  wire logic [7:0]                regWrData,
	input  wire logic                      regWrEn,
	input  wire logic                      regRdEn,
	output logic      [7:0]                regRdData,
	input  wire logic                      edgePin,
	input  wire logic [PORT_W-1:0]         portPins,
	input  wire logic                      timerOverflow,
	input  wire logic [7:0]                periphEvents,
	input  wire logic                      returnExec,
	input  wire logic [PC_W-1:0]           corePc,
	input  wire logic [BANK_W-1:0]         ramBank,
	input  wire logic [OFFS_W-1:0]         ramOffset,
	output logic      [BANK_W+OFFS_W-1:0]  ramPhysAddr,
	output logic      [3:0]                phaseQ,
	output logic                           irqRequest,
	output logic                           fetchSuppress,
	output logic                           stackPush,
	output logic      [PC_W-1:0]           stackPushData,
	output logic                           pcLoad,
	output logic      [PC_W-1:0]           pcLoadValue,
	output logic                           irqOut
);
	phase_t                   phase_q;
	seq_t                     seq_q;
	logic [7:0]               core_q;
	logic [7:0]               portSel_q;
	logic [7:0]               pFlags_q;
	logic [7:0]               pEn_q;
	logic                     edgePol_q;
	logic [EV_W-1:0]          evStat_q;
	logic [EV_W-1:0]          evMask_q;
	logic                     edgePend_q;
	logic [7:0]               regRdData_q;
	logic                     stackPush_q;
	logic [PC_W-1:0]          stackPushData_q;
	logic                     pcLoad_q;
	logic [BANK_W+OFFS_W-1:0] ramPhysAddr_q;
	logic                     edgeRise;
	logic                     edgeFall;
	logic [PORT_W-1:0]        portRise;
	logic [PORT_W-1:0]        portFall;
	logic [BANK_W+OFFS_W-1:0] mapAddr;
	logic                     edgeHit;
	logic                     portHit;
	logic                     edgeWindow;
	logic                     atQ1;
	logic                     takeIrq;
	logic                     wrCore;
	logic                     wrPFlags;
	logic                     rdEvStat;
	logic [7:0]               portSelWide;
	logic [EV_W-1:0]          evSet;

	irq_pin_sync #(.W(1)) u_edge_sync (
		.clk   (ref_clk),
		.rst_b (rst_b),
		.pinIn (edgePin),
		.rise  (edgeRise),
		.fall  (edgeFall)
	);

	irq_pin_sync #(.W(PORT_W)) u_port_sync (
		.clk   (ref_clk),
		.rst_b (rst_b),
		.pinIn (portPins),
		.rise  (portRise),
		.fall  (portFall)
	);

	irq_common_map u_map (
		.bankSel  (ramBank),
		.offset   (ramOffset),
		.physAddr (mapAddr)
	);

	assign wrCore     = regWrEn && (regAddr == ADDR_CORE);
	assign wrPFlags   = regWrEn && (regAddr == ADDR_PFLAGS);
	assign rdEvStat   = regRdEn && (regAddr == ADDR_EVSTAT);
	assign atQ1       = (phase_q == PH_Q1);
	assign edgeWindow = (phase_q == PH_Q4) || (phase_q == PH_Q1);
	assign portSelWide = portSel_q & PORTSEL_MASK;
	assign edgeHit = edgePol_q ? edgeRise : edgeFall;
	assign portHit = |((portRise | portFall) & portSelWide[PORT_W-1:0]);

	assign irqRequest = core_q[GLOBAL_EN_BIT] && (
		(core_q[TIMER_EN_BIT] && core_q[TIMER_FLAG_BIT]) ||
		(core_q[EDGE_EN_BIT] && core_q[EDGE_FLAG_BIT]) ||
		(core_q[PORT_EN_BIT] && core_q[PORT_FLAG_BIT]) ||
		(core_q[PERIPH_EN_BIT] && |(pFlags_q & pEn_q & PFLAGS_MASK)));

	// a request dropped before the push, e.g. global enable cleared, sends the sequencer back to idle with no push
	assign takeIrq = atQ1 && (seq_q == SEQ_ARMED) && irqRequest;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_q <= PH_Q1;
		end else begin
			case (phase_q)
				PH_Q1:   phase_q <= PH_Q2;
				PH_Q2:   phase_q <= PH_Q3;
				PH_Q3:   phase_q <= PH_Q4;
				PH_Q4:   phase_q <= PH_Q1;
				default: phase_q <= PH_Q1;
			endcase
		end
	end

	// sampled each Q1; sync stages may push an async event one cycle later
	// no wait for the running instruction; the core abandons its second cycle
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			seq_q <= SEQ_IDLE;
		end else if (atQ1) begin
			case (seq_q)
				SEQ_IDLE:   seq_q <= irqRequest ? SEQ_ARMED : SEQ_IDLE;
				SEQ_ARMED:  seq_q <= irqRequest ? SEQ_DUMMY : SEQ_IDLE;
				SEQ_DUMMY:  seq_q <= SEQ_VECTOR;
				SEQ_VECTOR: seq_q <= SEQ_IDLE;
				default:    seq_q <= SEQ_IDLE;
			endcase
		end
	end

	// only the return pc is pushed
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			stackPush_q     <= 1'b0;
			stackPushData_q <= '0;
			pcLoad_q        <= 1'b0;
		end else begin
			stackPush_q <= takeIrq;
			if (takeIrq) begin
				stackPushData_q <= corePc;
			end
			pcLoad_q <= atQ1 && (seq_q == SEQ_DUMMY);
		end
	end

	// pin edge waits for the Q4-Q1 window
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			edgePend_q <= 1'b0;
		// an edge inside the window is flagged at once; pending it too would re-set a cleared flag
		end else if (edgeHit && !edgeWindow) begin
			edgePend_q <= 1'b1;
		end else if (edgeWindow) begin
			edgePend_q <= 1'b0;
		end
	end

	// flags set regardless of enables; set beats software clear
	// return instruction wins over service clear and software write
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			core_q <= CORE_RESET;
		end else begin
			if (wrCore) begin
				core_q <= regWrData;
			end
			if (timerOverflow) begin
				core_q[TIMER_FLAG_BIT] <= 1'b1;
			end
			if ((edgePend_q || edgeHit) && edgeWindow) begin
				core_q[EDGE_FLAG_BIT] <= 1'b1;
			end
			if (portHit) begin
				core_q[PORT_FLAG_BIT] <= 1'b1;
			end
			if (takeIrq) begin
				core_q[GLOBAL_EN_BIT] <= 1'b0;
			end
			if (returnExec) begin
				core_q[GLOBAL_EN_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pFlags_q <= PFLAGS_RESET;
		end else begin
			pFlags_q <= ((wrPFlags ? regWrData : pFlags_q) | periphEvents) & PFLAGS_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			portSel_q <= PORTSEL_RESET;
			pEn_q     <= PEN_RESET;
			edgePol_q <= EDGE_POL_RESET;
			evMask_q  <= EV_RESET;
		end else if (regWrEn) begin
			case (regAddr)
				ADDR_PORTSEL: portSel_q <= regWrData & PORTSEL_MASK;
				ADDR_PEN:     pEn_q     <= regWrData & PFLAGS_MASK;
				ADDR_OPTION:  edgePol_q <= regWrData[EDGE_POL_BIT];
				ADDR_EVMASK:  evMask_q  <= regWrData[EV_W-1:0];
				default:      ;
			endcase
		end
	end

	always_comb begin
		evSet                = EV_RESET;
		evSet[EV_VECTOR_BIT] = pcLoad_q;
		evSet[EV_RETURN_BIT] = returnExec;
	end

	// read clears, but a same-cycle event survives
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			evStat_q <= EV_RESET;
		end else begin
			evStat_q <= (rdEvStat ? EV_RESET : evStat_q) | evSet;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdData_q <= 8'h00;
		end else if (regRdEn) begin
			case (regAddr)
				ADDR_CORE:    regRdData_q <= core_q;
				ADDR_PORTSEL: regRdData_q <= portSel_q;
				ADDR_PFLAGS:  regRdData_q <= pFlags_q;
				ADDR_PEN:     regRdData_q <= pEn_q;
				ADDR_OPTION:  regRdData_q <= {1'b0, edgePol_q, 6'h00};
				ADDR_EVSTAT:  regRdData_q <= {6'h00, evStat_q};
				ADDR_EVMASK:  regRdData_q <= {6'h00, evMask_q};
				default:      regRdData_q <= 8'h00;
			endcase
		end else begin
			regRdData_q <= 8'h00;
		end
	end

	// common low window registered onto the data address
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ramPhysAddr_q <= '0;
		end else begin
			ramPhysAddr_q <= mapAddr;
		end
	end

	assign regRdData     = regRdData_q;
	assign ramPhysAddr   = ramPhysAddr_q;
	assign phaseQ        = phase_q;
	assign stackPush     = stackPush_q;
	assign stackPushData = stackPushData_q;
	assign pcLoad        = pcLoad_q;
	assign pcLoadValue   = IRQ_VECTOR;
	assign fetchSuppress = (seq_q == SEQ_DUMMY) || (seq_q == SEQ_VECTOR);
	assign irqOut        = |(evStat_q & evMask_q);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	a_push_to_vector: assert property (stackPush |-> ##4 pcLoad)
		else $error("vector load not four clocks after push");
	a_enable_on_push: assert property (stackPush && !$past(returnExec) |-> !core_q[GLOBAL_EN_BIT])
		else $error("global enable still set after push");
	a_push_only_pc: assert property (stackPush |-> stackPushData == $past(corePc))
		else $error("pushed value is not the return pc");
	a_vector_value: assert property (pcLoad |-> pcLoadValue == IRQ_VECTOR && $past(fetchSuppress))
		else $error("vector load wrong");
	a_edge_window: assert property ($rose(core_q[EDGE_FLAG_BIT]) && !$past(wrCore) |->
		$past(phase_q) == PH_Q4 || $past(phase_q) == PH_Q1)
		else $error("edge flag set outside window");
	a_timer_flag: assert property (timerOverflow |=> core_q[TIMER_FLAG_BIT])
		else $error("timer flag not set");
	a_return_enable: assert property (returnExec |=> core_q[GLOBAL_EN_BIT])
		else $error("return did not set global enable");
	a_request_gate: assert property (irqRequest |-> core_q[GLOBAL_EN_BIT])
		else $error("request without global enable");
	a_timer_request: assert property (core_q[GLOBAL_EN_BIT] && core_q[TIMER_EN_BIT] &&
		core_q[TIMER_FLAG_BIT] |-> irqRequest)
		else $error("enabled timer flag raises no request");
	a_port_flag: assert property (portHit |=> core_q[PORT_FLAG_BIT])
		else $error("port change flag not set");
	a_common_map: assert property (ramOffset < COMMON_SIZE |=> ramPhysAddr[BANK_W+OFFS_W-1:OFFS_W] == '0)
		else $error("common location banked");
	a_sync_latency: assert property (atQ1 && seq_q == SEQ_IDLE && irqRequest
		##4 irqRequest |-> ##[5:9] pcLoad)
		else $error("vector not reached in time");
	a_armed_fixed: assert property ($rose(seq_q == SEQ_ARMED) |-> (seq_q == SEQ_ARMED)[*4])
		else $error("armed cycle length varies");

	c_vector: cover property (stackPush ##4 pcLoad);
	c_periph: cover property (irqRequest && core_q[PERIPH_EN_BIT] && |(pFlags_q & pEn_q));
	c_return: cover property (returnExec && !core_q[GLOBAL_EN_BIT]);
endmodule
`default_nettype wire

//--- bench/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model
	import irq_flag_pkg::*;
(
	input  wire logic            ref_clk,
	input  wire logic            rst_b,
	input  wire logic [3:0]      phaseQ,
	input  wire logic            fetchSuppress,
	input  wire logic            stackPush,
	input  wire logic [PC_W-1:0] stackPushData,
	input  wire logic            pcLoad,
	input  wire logic [PC_W-1:0] pcLoadValue,
	input  wire logic            doReturn,
	output logic      [PC_W-1:0] corePc,
	output logic                 returnExec
);
	logic [PC_W-1:0] pc_q;
	logic [PC_W-1:0] savedPc_q;

	assign corePc = pc_q;

	// context kept by service code, only the pc comes back from the stack
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pc_q <= '0;
			savedPc_q <= '0;
			returnExec <= 1'b0;
		end else begin
			returnExec <= doReturn;
			if (stackPush)
				savedPc_q <= stackPushData;
			if (pcLoad)
				pc_q <= pcLoadValue;
			else if (doReturn)
				pc_q <= savedPc_q;
			// fetch stalls during the dummy cycles
			else if (phaseQ == PH_Q4 && !fetchSuppress)
				pc_q <= pc_q + 13'h0001;
		end
	end
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import irq_flag_pkg::*;
	logic ref_clk = 0, rst_b = 0, regWrEn = 0, regRdEn = 0, edgePin = 0;
	logic timerOverflow = 0, doReturn = 0, returnExec, irqRequest, fetchSuppress;
	logic stackPush, pcLoad, irqOut;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [7:0] regWrData = '0, regRdData, periphEvents = '0, rdv;
	logic [PC_W-1:0] corePc, stackPushData, pcLoadValue;
	logic [BANK_W-1:0] ramBank = '0;
	logic [OFFS_W-1:0] ramOffset = '0;
	logic [PORT_W-1:0] portPins = '0;
	logic [BANK_W+OFFS_W-1:0] ramPhysAddr;
	logic [3:0] phaseQ;
	int n_fail = 0, checked = 0;
	logic [7:0] resetVals [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};

	always #4 ref_clk = ~ref_clk;

	irq_flag_vector_logic irq_flag_vector_logic_inst (.ref_clk(ref_clk), .rst_b(rst_b),
		.regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .edgePin(edgePin), .portPins(portPins),
		.timerOverflow(timerOverflow), .periphEvents(periphEvents), .returnExec(returnExec),
		.corePc(corePc), .ramBank(ramBank), .ramOffset(ramOffset), .ramPhysAddr(ramPhysAddr),
		.phaseQ(phaseQ), .irqRequest(irqRequest), .fetchSuppress(fetchSuppress),
		.stackPush(stackPush), .stackPushData(stackPushData), .pcLoad(pcLoad),
		.pcLoadValue(pcLoadValue), .irqOut(irqOut));

	core_model core_model_inst (.ref_clk(ref_clk), .rst_b(rst_b), .phaseQ(phaseQ),
		.fetchSuppress(fetchSuppress), .stackPush(stackPush), .stackPushData(stackPushData),
		.pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .doReturn(doReturn), .corePc(corePc),
		.returnExec(returnExec));

	task automatic end_of_test;
		$display("compares %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
	endtask

	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		#1 chk({5'h00, regRdData}, {5'h00, exp});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// waits for the vector load, counting clocks and pushes on the way
	task automatic vec(input int lo, input int hi);
		int n;
		int pushes;
		n = 0;
		pushes = 0;
		while (pcLoad !== 1'b1 && n < 40) begin
			@(posedge ref_clk);
			#1 n++;
			if (stackPush === 1'b1) begin
				pushes++;
				chk(stackPushData, corePc);
				chk(13'(fetchSuppress), 13'h0001);
			end
		end
		if (n >= 40) begin
			chk(13'h0000, 13'h0001);
			end_of_test();
		end
		chk(13'(n >= lo && n <= hi), 13'h0001);
		chk(pcLoadValue, IRQ_VECTOR);
		chk(13'(pushes), 13'h0001);
	endtask

	task automatic ret;
		@(posedge ref_clk);
		doReturn <= 1'b1;
		@(posedge ref_clk);
		doReturn <= 1'b0;
		tick(2);
	endtask

	initial begin
		int i;
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		for (i = 0; i < 8; i++)
			rdc(3'(i), resetVals[i]);
		$display("reset values done");
		@(posedge ref_clk);
		timerOverflow <= 1'b1;
		periphEvents <= 8'h81;
		@(posedge ref_clk);
		timerOverflow <= 1'b0;
		periphEvents <= 8'h00;
		rdc(ADDR_CORE, 8'h04);
		rdc(ADDR_PFLAGS, 8'h81);
		wr(ADDR_PEN, 8'h01);
		wr(ADDR_CORE, 8'h40);
		tick(1);
		chk(13'(irqRequest), 13'h0000);
		wr(ADDR_EVMASK, 8'h01);
		wr(ADDR_CORE, 8'hC0);
		tick(1);
		chk(13'(irqRequest), 13'h0001);
		vec(1, 20);
		tick(1);
		chk(13'(irqOut), 13'h0001);
		rdc(ADDR_CORE, 8'h40);
		rdc(ADDR_EVSTAT, 8'h01);
		chk(13'(irqOut), 13'h0000);
		wr(ADDR_PFLAGS, 8'h00);
		ret();
		rdc(ADDR_CORE, 8'hC0);
		rdc(ADDR_EVSTAT, 8'h02);
		$display("peripheral vector done");
		wr(ADDR_CORE, 8'h90);
		@(posedge ref_clk);
		edgePin <= 1'b1;
		// flag window plus pin synchroniser stretch the async latency
		vec(3 * PHASES_PER_TCY, 4 * PHASES_PER_TCY);
		rdc(ADDR_CORE, 8'h12);
		wr(ADDR_CORE, 8'h10);
		ret();
		$display("edge vector done");
		wr(ADDR_CORE, 8'hA0);
		i = 0;
		while (phaseQ !== PH_Q4 && i < 8) begin
			tick(1);
			i++;
		end
		chk(13'(phaseQ), 13'(PH_Q4));
		if (phaseQ !== PH_Q4)
			end_of_test();
		@(posedge ref_clk);
		timerOverflow <= 1'b1;
		@(posedge ref_clk);
		timerOverflow <= 1'b0;
		vec(LATENCY_CLKS, LATENCY_CLKS);
		rdc(ADDR_CORE, 8'h24);
		ret();
		$display("timer vector done");
		wr(ADDR_CORE, 8'h00);
		wr(ADDR_OPTION, 8'h00);
		@(posedge ref_clk);
		edgePin <= 1'b0;
		tick(12);
		rdc(ADDR_CORE, 8'h02);
		wr(ADDR_CORE, 8'h00);
		@(posedge ref_clk);
		edgePin <= 1'b1;
		tick(12);
		rdc(ADDR_CORE, 8'h00);
		$display("edge polarity done");
		@(posedge ref_clk);
		ramBank <= 2'h2;
		ramOffset <= 7'h05;
		tick(2);
		chk(13'(ramPhysAddr), 13'h0005);
		@(posedge ref_clk);
		ramOffset <= 7'h10;
		tick(2);
		chk(13'(ramPhysAddr), 13'h0110);
		$display("common bank map done");
		wr(ADDR_PORTSEL, 8'h01);
		@(posedge ref_clk);
		portPins <= 6'h01;
		tick(6);
		rdc(ADDR_CORE, 8'h01);
		rdc(ADDR_PORTSEL, 8'h01);
		wr(ADDR_CORE, 8'h00);
		@(posedge ref_clk);
		portPins <= 6'h03;
		tick(6);
		rdc(ADDR_CORE, 8'h00);
		$display("port change done");
		end_of_test();
	end
endmodule
`default_nettype wire
